// ### hdl/pir_top.sv
`timescale 1ns/1ns
// Overview of operation
// - Serves both legacy controller mode and advanced controller mode, chosen by i_apic_mode.
// - Two cascaded controllers; secondary levels 8 to 15 enter primary level 2.
// - Legacy mode drives one interrupt output, serviced by a single processor.
// - Writable map chooses the source feeding each I/O controller pin.
// - PCI and legacy interrupts are collected and sent as serial bus messages.
// - Each board line is assigned one numbered PCI interrupt input.
// - Disk interface INTA goes to PCI input 3.
// - Second segment slot 3 INTA to INTD go to inputs 7, 6, 9, 8.
// - Second segment slot 2 INTA to INTD go to inputs 8, 7, 6, 9.
// - Second segment slot 1 INTA to INTD go to inputs 9, 8, 7, 6.
// - First segment slot 3 INTA to INTD go to inputs 13, 12, 15, 14.
// - First segment slot 2 INTA to INTD go to inputs 14, 13, 12, 15.
// - First segment slot 1 INTA to INTD go to inputs 15, 14, 12, 11.
// - Second storage channel interrupts on INTB into PCI input 10.
// - Serial bus is one clock line and two bidirectional data lines.
module pir_top
(
  input  wire logic         i_sys_clk,
  input  wire logic         i_reset_n,
  input  wire logic         i_video_int_n,
  input  wire logic         i_disk_int_n,
  input  wire logic         i_net_second_int_n,
  input  wire logic         i_net_first_int_n,
  input  wire logic [11:0]  i_wide_pci_segment_second_int_n,
  input  wire logic [11:0]  i_wide_pci_segment_first_int_n,
  input  wire logic         i_storage_channel_first_int_n,
  input  wire logic         i_storage_channel_second_int_n,
  input  wire logic [15:0]  i_isa_irq,
  input  wire logic         i_int_ack,
  input  wire logic         i_eoi,
  input  wire logic         i_eoi_sec,
  input  wire logic [15:0]  i_pic_mask,
  input  wire logic         i_apic_mode,
  input  wire logic         i_map_wr,
  input  wire logic [4:0]   i_map_pin,
  input  wire logic [4:0]   i_map_src,
  input  wire logic [1:0]   i_bus_data_i,
  output logic              o_intr,
  output logic [7:0]        o_vector,
  output logic              o_vector_valid,
  output logic [15:0]       o_pci_in_n,
  output logic              o_bus_clk,
  output logic [1:0]        o_bus_data_o,
  output logic [1:0]        o_bus_data_oe
);

  localparam int SYNC_W = pir_pkg::PIR_NUM_SRC + 20;
  localparam logic [SYNC_W-1:0] SYNC_IDLE = {2'h0, 2'h3, 16'h0000, {pir_pkg::PIR_NUM_SRC{1'b1}}}; // Idle pin levels.

  // Pin inputs pass two flip-flops; only stage two feeds logic.
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  logic [1:0]        edge_reg;
  logic [pir_pkg::PIR_NUM_SRC-1:0] src_act;
  logic [15:0] isa_lvl;
  logic [1:0]  bus_in;
  logic        ack_pulse;
  logic        eoi_pulse;

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_reset_n)
    begin
      // Stages reset to idle pin levels, so no phantom request follows reset.
      sync1_reg <= SYNC_IDLE;
      sync2_reg <= SYNC_IDLE;
      edge_reg  <= 2'h0;
    end
    else
    begin
      sync1_reg <= {i_int_ack, i_eoi, i_bus_data_i, i_isa_irq,
                    i_storage_channel_second_int_n, i_storage_channel_first_int_n,
                    i_wide_pci_segment_first_int_n, i_wide_pci_segment_second_int_n,
                    i_net_first_int_n, i_net_second_int_n, i_disk_int_n, i_video_int_n};
      sync2_reg <= sync1_reg;
      edge_reg  <= sync2_reg[SYNC_W-1 -: 2];
    end
  end

  // Board lines are active low; sources are kept active high inside.
  // video line source 0
  assign src_act   = ~sync2_reg[pir_pkg::PIR_NUM_SRC-1:0];
  assign isa_lvl   = sync2_reg[pir_pkg::PIR_NUM_SRC +: 16];
  assign bus_in    = sync2_reg[pir_pkg::PIR_NUM_SRC+16 +: 2];
  assign ack_pulse = sync2_reg[SYNC_W-1] & ~edge_reg[1];
  assign eoi_pulse = sync2_reg[SYNC_W-2] & ~edge_reg[0];

  logic [15:0] pci_lvl_reg;
  logic [15:0] pci_lvl_next;

  always_comb
  begin
    pci_lvl_next = 16'h0000;
    for (int s = 0; s < pir_pkg::PIR_NUM_SRC; s++)
    begin
      if (src_act[s])
        pci_lvl_next[pir_pkg::PIR_ROUTE[s]] = 1'b1;
    end
    if (!i_reset_n)
      pci_lvl_next = 16'h0000;
  end

  always_ff @(posedge i_sys_clk)
  begin
    pci_lvl_reg <= pci_lvl_next;
    o_pci_in_n  <= ~pci_lvl_next;
  end

  // Legacy levels: input 2 is redirected since level 2 carries the cascade.
  logic [15:0] leg_irq;
  logic [7:0]  pri_irq;
  logic        pri_int;
  logic        sec_int;
  logic [2:0]  pri_lvl;
  logic [2:0]  sec_lvl;
  logic        pri_ack;
  logic        sec_ack;

  always_comb
  begin
    leg_irq    = isa_lvl | pci_lvl_reg;
    leg_irq[2] = isa_lvl[2];
    leg_irq[pir_pkg::PIR_PCI2_IRQ] = leg_irq[pir_pkg::PIR_PCI2_IRQ] | pci_lvl_reg[2];
    pri_irq = leg_irq[7:0];
    pri_irq[pir_pkg::PIR_CASCADE_LVL] = sec_int;
    pri_ack = ack_pulse && !i_apic_mode;
    sec_ack = pri_ack && pri_int && (pri_lvl == pir_pkg::PIR_CASCADE_LVL);
  end

  pir_pic u_pic_pri
  (
    .i_sys_clk (i_sys_clk),
    .i_reset_n (i_reset_n),
    .i_irq     (pri_irq),
    .i_mask    (i_pic_mask[7:0]),
    .i_ack     (pri_ack),
    .i_eoi     (eoi_pulse),
    .o_int     (pri_int),
    .o_level   (pri_lvl)
  );

  pir_pic u_pic_sec
  (
    .i_sys_clk (i_sys_clk),
    .i_reset_n (i_reset_n),
    .i_irq     (leg_irq[15:8]),
    .i_mask    (i_pic_mask[15:8]),
    .i_ack     (sec_ack),
    .i_eoi     (eoi_pulse & i_eoi_sec),
    .o_int     (sec_int),
    .o_level   (sec_lvl)
  );

  logic [7:0] vec_next;
  logic       vec_vld_next;
  logic       intr_next;

  always_comb
  begin
    intr_next    = pri_int && !i_apic_mode;
    vec_next     = o_vector;
    vec_vld_next = 1'b0;
    if (pri_ack && pri_int)
    begin
      vec_vld_next = 1'b1;
      vec_next     = sec_ack ? pir_pkg::PIR_SEC_VEC + 8'(sec_lvl) : pir_pkg::PIR_PRI_VEC + 8'(pri_lvl);
    end
    if (!i_reset_n)
    begin
      intr_next = 1'b0;
      vec_next  = 8'h00;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    o_intr         <= intr_next;
    o_vector       <= vec_next;
    o_vector_valid <= vec_vld_next;
  end

  // Map scan: one pin per cycle; a rising source level marks the pin pending.
  logic [4:0]  scan_reg;
  logic [4:0]  scan_prev_reg;
  logic [4:0]  map_data;
  logic [31:0] pin_lvl_reg;
  logic [31:0] pin_lvl_next;
  logic [31:0] pend_reg;
  logic [31:0] pend_next;
  logic        src_lvl;

  pir_map_mem u_map
  (
    .i_sys_clk (i_sys_clk),
    .i_reset_n (i_reset_n),
    .i_wr_en   (i_map_wr),
    .i_wr_addr (i_map_pin),
    .i_wr_data (i_map_src),
    .i_rd_addr (scan_reg),
    .o_rd_data (map_data)
  );

  // Serial transmitter state.
  pir_pkg::pir_tx_state_t tx_state_reg;
  pir_pkg::pir_tx_state_t tx_state_next;
  logic [3:0] div_reg;
  logic [3:0] div_next;
  logic       clk_next;
  logic [9:0] shift_reg;
  logic [9:0] shift_next;
  logic [2:0] pairs_reg;
  logic [2:0] pairs_next;
  logic [4:0] tx_pin_reg;
  logic [4:0] tx_pin_next;
  logic [1:0] oe_next;
  logic       tick;
  logic       fall;
  logic       rise;
  logic       done;
  logic [4:0] low_pin;
  logic       any_pend;

  always_comb
  begin
    src_lvl      = map_data[4] ? pci_lvl_reg[map_data[3:0]] : isa_lvl[map_data[3:0]];
    pin_lvl_next = pin_lvl_reg;
    pin_lvl_next[scan_prev_reg] = src_lvl;
    pend_next    = pend_reg;
    // A new edge wins over the clear of the message that just went out.
    if (done)
      pend_next[tx_pin_reg] = 1'b0;
    if (i_apic_mode && src_lvl && !pin_lvl_reg[scan_prev_reg])
      pend_next[scan_prev_reg] = 1'b1;
    if (!i_apic_mode)
      pend_next = '0;
    low_pin  = 5'h00;
    any_pend = 1'b0;
    for (int p = pir_pkg::PIR_NUM_PINS - 1; p >= 0; p--)
    begin
      if (pend_reg[p])
      begin
        low_pin  = 5'(p);
        any_pend = 1'b1;
      end
    end
    if (!i_reset_n)
    begin
      pin_lvl_next = '0;
      pend_next    = '0;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    scan_reg      <= i_reset_n ? scan_reg + 5'h01 : 5'h00;
    scan_prev_reg <= i_reset_n ? scan_reg : 5'h00;
    pin_lvl_reg   <= pin_lvl_next;
    pend_reg      <= pend_next;
  end

  // clock and two open-drain data lines
  // Data changes on the falling edge and is checked on the rising edge;
  // a released line found low means another agent won, so we back off.
  always_comb
  begin
    tick          = (div_reg == pir_pkg::PIR_BUS_HALF_LAST);
    div_next      = tick ? 4'h0 : div_reg + 4'h1;
    clk_next      = tick ? ~o_bus_clk : o_bus_clk;
    fall          = tick && o_bus_clk;
    rise          = tick && !o_bus_clk;
    tx_state_next = tx_state_reg;
    shift_next    = shift_reg;
    pairs_next    = pairs_reg;
    tx_pin_next   = tx_pin_reg;
    oe_next       = o_bus_data_oe;
    done          = 1'b0;
    case (tx_state_reg)
      pir_pkg::PIR_TX_IDLE:
      begin
        oe_next = 2'h0;
        if (fall && any_pend && (bus_in == 2'h3))
        begin
          tx_pin_next   = low_pin;
          shift_next    = {pir_pkg::PIR_MSG_END, 1'b0, low_pin, pir_pkg::PIR_MSG_START};
          pairs_next    = pir_pkg::PIR_MSG_PAIRS;
          oe_next       = ~pir_pkg::PIR_MSG_START;
          tx_state_next = pir_pkg::PIR_TX_SEND;
        end
      end
      pir_pkg::PIR_TX_SEND:
      begin
        if (rise && ((bus_in & ~o_bus_data_oe) != ~o_bus_data_oe))
        begin
          oe_next       = 2'h0;
          tx_state_next = pir_pkg::PIR_TX_BACKOFF;
        end
        else if (fall)
        begin
          shift_next = {2'h3, shift_reg[9:2]};
          pairs_next = pairs_reg - 3'h1;
          if (pairs_reg == 3'h1)
          begin
            oe_next       = 2'h0;
            done          = 1'b1;
            tx_state_next = pir_pkg::PIR_TX_IDLE;
          end
          else
            oe_next = ~shift_reg[3:2];
        end
      end
      pir_pkg::PIR_TX_BACKOFF:
      begin
        oe_next = 2'h0;
        if (fall && (bus_in == 2'h3))
          tx_state_next = pir_pkg::PIR_TX_IDLE;
      end
      default:
      begin
        oe_next       = 2'h0;
        tx_state_next = pir_pkg::PIR_TX_IDLE;
      end
    endcase
    if (!i_reset_n)
    begin
      tx_state_next = pir_pkg::PIR_TX_IDLE;
      div_next      = 4'h0;
      clk_next      = 1'b0;
      oe_next       = 2'h0;
      shift_next    = 10'h3ff;
      pairs_next    = 3'h0;
      tx_pin_next   = 5'h00;
      done          = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    tx_state_reg  <= tx_state_next;
    div_reg       <= div_next;
    o_bus_clk     <= clk_next;
    shift_reg     <= shift_next;
    pairs_reg     <= pairs_next;
    tx_pin_reg    <= tx_pin_next;
    o_bus_data_oe <= oe_next;
    o_bus_data_o  <= 2'h0;
  end

endmodule

// ### inc/pir_pkg.sv
package pir_pkg;

  // Board interrupt lines, numbered PCI inputs and I/O controller pins.
  localparam int PIR_NUM_SRC  = 30;
  localparam int PIR_NUM_PCI  = 16;
  localparam int PIR_NUM_PINS = 32;
  localparam int PIR_PIN_W    = 5;

  // Numbered PCI input for each board line, in source order.
  localparam logic [3:0] PIR_ROUTE [0:PIR_NUM_SRC-1] = '{
    4'h2, 4'h3, 4'h4, 4'h5,
    4'h7, 4'h6, 4'h9, 4'h8,
    4'h8, 4'h7, 4'h6, 4'h9,
    4'h9, 4'h8, 4'h7, 4'h6,
    4'hd, 4'hc, 4'hf, 4'he,
    4'he, 4'hd, 4'hc, 4'hf,
    4'hf, 4'he, 4'hc, 4'hb,
    4'hb, 4'ha};

  // Legacy controllers: cascade level, vector bases, redirect of input 2.
  localparam logic [2:0] PIR_CASCADE_LVL = 3'h2;
  localparam logic [3:0] PIR_PCI2_IRQ    = 4'h9;
  localparam logic [7:0] PIR_PRI_VEC     = 8'h08;
  localparam logic [7:0] PIR_SEC_VEC     = 8'h70;

  // Serial bus clock: half period in ns and in system clock cycles.
  localparam int PIR_CLK_NS       = 40;
  localparam int PIR_BUS_HALF_NS  = 160;
  localparam int PIR_BUS_HALF_CYC = (PIR_BUS_HALF_NS / PIR_CLK_NS < 1) ? 1 : PIR_BUS_HALF_NS / PIR_CLK_NS;
  localparam logic [3:0] PIR_BUS_HALF_LAST = 4'(PIR_BUS_HALF_CYC - 1);

  // Message: start pair, five pin bits and a zero bit, end pair; five bit pairs in all.
  localparam logic [1:0] PIR_MSG_START = 2'h0;
  localparam logic [1:0] PIR_MSG_END   = 2'h3;
  localparam logic [2:0] PIR_MSG_PAIRS = 3'h5;

  typedef enum logic [1:0] {PIR_TX_IDLE, PIR_TX_SEND, PIR_TX_BACKOFF} pir_tx_state_t;

endpackage

// ### hdl/pir_map_mem.sv
`timescale 1ns/1ns
// Source map: one entry per I/O controller pin, registered read port.
module pir_map_mem
(
  input  wire logic                           i_sys_clk,
  input  wire logic                           i_reset_n,
  input  wire logic                           i_wr_en,
  input  wire logic [pir_pkg::PIR_PIN_W-1:0]  i_wr_addr,
  input  wire logic [pir_pkg::PIR_PIN_W-1:0]  i_wr_data,
  input  wire logic [pir_pkg::PIR_PIN_W-1:0]  i_rd_addr,
  output logic      [pir_pkg::PIR_PIN_W-1:0]  o_rd_data
);

  logic [pir_pkg::PIR_PIN_W-1:0] mem_reg  [0:pir_pkg::PIR_NUM_PINS-1];
  logic [pir_pkg::PIR_PIN_W-1:0] mem_next [0:pir_pkg::PIR_NUM_PINS-1];

  // Entries reset to identity so every pin has a source before software writes.
  always_comb
  begin
    for (int i = 0; i < pir_pkg::PIR_NUM_PINS; i++)
    begin
      if (!i_reset_n)
        mem_next[i] = pir_pkg::PIR_PIN_W'(i);
      else if (i_wr_en && (i_wr_addr == pir_pkg::PIR_PIN_W'(i)))
        mem_next[i] = i_wr_data;
      else
        mem_next[i] = mem_reg[i];
    end
  end

  // Read data is old data when the same entry is written in that cycle.
  always_ff @(posedge i_sys_clk)
  begin
    mem_reg   <= mem_next;
    o_rd_data <= i_reset_n ? mem_reg[i_rd_addr] : '0;
  end

endmodule

// ### hdl/pir_pic.sv
`timescale 1ns/1ns
// One eight-level priority controller; level 0 is highest.
module pir_pic
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset_n,
  input  wire logic [7:0]  i_irq,
  input  wire logic [7:0]  i_mask,
  input  wire logic        i_ack,
  input  wire logic        i_eoi,
  output logic             o_int,
  output logic [2:0]       o_level
);

  logic [7:0] isr_reg;
  logic [7:0] isr_next;
  logic [7:0] req;
  logic [2:0] isr_lvl;
  logic       isr_any;
  logic       req_any;

  // Resolve highest pending request and highest level in service.
  always_comb
  begin
    req     = i_irq & ~i_mask & ~isr_reg;
    o_level = 3'h0;
    req_any = 1'b0;
    isr_lvl = 3'h0;
    isr_any = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      if (req[i])
      begin
        o_level = 3'(i);
        req_any = 1'b1;
      end
      if (isr_reg[i])
      begin
        isr_lvl = 3'(i);
        isr_any = 1'b1;
      end
    end
    // Only a level above the one in service may interrupt it.
    o_int = req_any && (!isr_any || (o_level < isr_lvl));
  end

  // End of interrupt retires first, then an acknowledge marks a new level.
  always_comb
  begin
    isr_next = isr_reg;
    if (i_eoi && isr_any)
      isr_next[isr_lvl] = 1'b0;
    if (i_ack && o_int)
      isr_next[o_level] = 1'b1;
    if (!i_reset_n)
      isr_next = 8'h00;
  end

  always_ff @(posedge i_sys_clk)
  begin
    isr_reg <= isr_next;
  end

endmodule

// ### test/pir_top_checker.sv
`timescale 1ns/1ns
// Watches routing, legacy answer and serial bus outputs from the top ports alone.
module pir_top_checker
(
  input wire logic         i_sys_clk,
  input wire logic         i_reset_n,
  input wire logic         i_video_int_n,
  input wire logic         i_disk_int_n,
  input wire logic         i_storage_channel_first_int_n,
  input wire logic [11:0]  i_wide_pci_segment_second_int_n,
  input wire logic [11:0]  i_wide_pci_segment_first_int_n,
  input wire logic         i_apic_mode,
  input wire logic [7:0]   o_vector,
  input wire logic         o_vector_valid,
  input wire logic [15:0]  o_pci_in_n,
  input wire logic         o_bus_clk,
  input wire logic [1:0]   o_bus_data_o
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);

  // Three low samples pass two sync stages and one register before the input drops.
  // video input two
  a_video_route: assert property ((!i_video_int_n)[*3] |=> !o_pci_in_n[2])
    else $error("video line not routed to input 2");
  a_disk_route: assert property ($stable(i_disk_int_n)[*3] |=> o_pci_in_n[3] == $past(i_disk_int_n))
    else $error("disk line not followed on input 3");
  a_storage_share: assert property ((!i_storage_channel_first_int_n)[*3] |=> !o_pci_in_n[11])
    else $error("storage line not routed to input 11");
  a_slot_second: assert property ((!i_wide_pci_segment_second_int_n[0])[*3] |=> !o_pci_in_n[7])
    else $error("second segment slot line not routed to input 7");
  a_slot_first: assert property ((!i_wide_pci_segment_first_int_n[10])[*3] |=> !o_pci_in_n[12])
    else $error("first segment slot line not routed to input 12");
  a_unused_high: assert property (o_pci_in_n[1:0] == 2'h3)
    else $error("unused numbered inputs asserted");
  a_vec_pulse: assert property (o_vector_valid |=> !o_vector_valid)
    else $error("vector valid longer than one cycle");
  a_vec_range: assert property (o_vector_valid |-> o_vector inside {[8'h08:8'h0f], [8'h70:8'h77]})
    else $error("vector outside both controller ranges");
  a_apic_refuse: assert property (i_apic_mode[*4] |-> !o_vector_valid)
    else $error("legacy vector given in serial mode");
  a_open_drain: assert property (o_bus_data_o == 2'h0)
    else $error("serial data driven high");
  a_busclk_half: assert property ($rose(o_bus_clk) |-> o_bus_clk[*4])
    else $error("bus clock high phase too short");
endmodule

bind pir_top pir_top_checker u_pir_top_checker (.*);

// ### test/pir_bus_partner.sv
`timescale 1ns/1ns
// Processor side of the serial bus: pull-ups on both lines and a message receiver.
module pir_bus_partner
(
  input  wire logic        i_bus_clk,
  input  wire logic [1:0]  i_oe,
  output logic      [1:0]  o_line,
  output logic      [4:0]  o_pin,
  output logic      [7:0]  o_msg_count,
  output logic             o_frame_err
);
  logic [2:0]  pair_idx;
  logic [4:0]  bits;

  assign o_line = ~i_oe;

  initial
  begin
    pair_idx    = 3'h0;
    bits        = 5'h0;
    o_pin       = 5'h0;
    o_msg_count = 8'h0;
    o_frame_err = 1'b0;
  end

  // Pairs are sampled on rising bus clock; a both-low pair opens a message.
  // serial message receive
  always @(posedge i_bus_clk)
  begin
    if (pair_idx == 3'h0)
    begin
      if (o_line == 2'h0)
        pair_idx <= 3'h1;
    end
    else
    begin
      if (pair_idx == 3'h1)
        bits[1:0] <= o_line;
      if (pair_idx == 3'h2)
        bits[3:2] <= o_line;
      if (pair_idx == 3'h3)
        bits[4] <= o_line[0];
      if (pair_idx == 3'h4)
      begin
        o_pin       <= bits;
        o_msg_count <= o_msg_count + 8'h1;
        if (o_line != 2'h3)
          o_frame_err <= 1'b1;
        pair_idx <= 3'h0;
      end
      else
        pair_idx <= pair_idx + 3'h1;
    end
  end
endmodule

// ### test/tb_pir_top.sv
`timescale 1ns/1ns
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin err_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end

module tb_pir_top;
  logic         i_sys_clk, i_reset_n, i_int_ack, i_eoi, i_eoi_sec, i_apic_mode, i_map_wr;
  logic [29:0]  src_n;
  logic [15:0]  i_isa_irq, i_pic_mask;
  logic [4:0]   i_map_pin, i_map_src;
  logic         o_intr, o_vector_valid, o_bus_clk, frame_err;
  logic [7:0]   o_vector, msg_count;
  logic [15:0]  o_pci_in_n;
  logic [1:0]   o_bus_data_oe, line;
  logic [4:0]   msg_pin;
  int           err_count, samples_checked;

  // Numbered input of each board line: four on-board, two segments, two storage channels.
  localparam logic [3:0] ROUTE_EXP [30] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'h6, 4'h9, 4'h8, 4'h8, 4'h7,
    4'h6, 4'h9, 4'h9, 4'h8, 4'h7, 4'h6, 4'hd, 4'hc, 4'hf, 4'he, 4'he, 4'hd, 4'hc, 4'hf, 4'hf, 4'he,
    4'hc, 4'hb, 4'hb, 4'ha};

  pir_top u_pir_top (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_video_int_n(src_n[0]),
    .i_disk_int_n(src_n[1]), .i_net_second_int_n(src_n[2]), .i_net_first_int_n(src_n[3]),
    .i_wide_pci_segment_second_int_n(src_n[15:4]), .i_wide_pci_segment_first_int_n(src_n[27:16]),
    .i_storage_channel_first_int_n(src_n[28]), .i_storage_channel_second_int_n(src_n[29]),
    .i_isa_irq(i_isa_irq), .i_int_ack(i_int_ack), .i_eoi(i_eoi), .i_eoi_sec(i_eoi_sec),
    .i_pic_mask(i_pic_mask), .i_apic_mode(i_apic_mode), .i_map_wr(i_map_wr), .i_map_pin(i_map_pin),
    .i_map_src(i_map_src), .i_bus_data_i(line), .o_intr(o_intr), .o_vector(o_vector),
    .o_vector_valid(o_vector_valid), .o_pci_in_n(o_pci_in_n), .o_bus_clk(o_bus_clk),
    .o_bus_data_o(), .o_bus_data_oe(o_bus_data_oe));

  pir_bus_partner u_pir_bus_partner (.i_bus_clk(o_bus_clk), .i_oe(o_bus_data_oe), .o_line(line),
    .o_pin(msg_pin), .o_msg_count(msg_count), .o_frame_err(frame_err));

  // Free-running system clock.
  initial
  begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end

  // Any low sharer pulls its numbered input low.
  function automatic logic [15:0] exp_pci(input logic [29:0] s);
    exp_pci = 16'hffff;
    for (int i = 0; i < 30; i++)
      if (!s[i])
        exp_pci[ROUTE_EXP[i]] = 1'b0;
  endfunction

  task automatic check_route(input logic [29:0] s);
    @(posedge i_sys_clk) src_n <= s;
    repeat (4) @(posedge i_sys_clk);
    #1 `CHK(o_pci_in_n, exp_pci(s))
  endtask

  // The acknowledge is held four cycles so the synchronizer sees it.
  task automatic ack_expect(input logic hit_exp, input logic [7:0] vec_exp);
    logic       hit;
    logic [7:0] got;
    hit = 1'b0;
    got = 8'h0;
    @(posedge i_sys_clk) i_int_ack <= 1'b1;
    for (int i = 0; i < 12; i++)
    begin
      @(posedge i_sys_clk);
      if (i == 3)
        i_int_ack <= 1'b0;
      #1 if (o_vector_valid === 1'b1)
      begin
        hit = 1'b1;
        got = o_vector;
      end
    end
    `CHK(hit, hit_exp)
    if (hit_exp)
      `CHK(got, vec_exp)
  endtask

  task automatic pulse_eoi(input logic sec);
    @(posedge i_sys_clk);
    i_eoi     <= 1'b1;
    i_eoi_sec <= sec;
    repeat (3) @(posedge i_sys_clk);
    i_eoi     <= 1'b0;
    i_eoi_sec <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
  endtask

  // Bounded wait: scan plus one five-pair message fits well inside the limit.
  task automatic wait_msg(input logic [4:0] pin_exp);
    logic [7:0] c0;
    c0 = msg_count;
    for (int n = 0; n < 400 && msg_count === c0; n++)
      @(posedge i_sys_clk);
    `CHK(msg_pin, pin_exp)
  endtask

  task automatic finish_test();
    $display("errors %0d, comparisons %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Main sequence: legacy answers, line routing, then serial messages.
  initial
  begin
    {i_reset_n, i_int_ack, i_eoi, i_eoi_sec, i_apic_mode, i_map_wr} = 6'h0;
    src_n = '1;
    {i_isa_irq, i_pic_mask} = 32'h0;
    {i_map_pin, i_map_src} = 10'h0;
    err_count = 0;
    samples_checked = 0;
    void'($urandom(32'h024ce6c6));
    fork
      begin
        #400000;
        err_count++;
        finish_test();
      end
    join_none
    repeat (2) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    i_isa_irq <= 16'h0008;
    repeat (5) @(posedge i_sys_clk);
    #1 `CHK(o_intr, 1'b1)
    ack_expect(1'b1, 8'h0b);
    @(posedge i_sys_clk) i_isa_irq <= 16'h0;
    pulse_eoi(1'b0);
    i_isa_irq <= 16'h1000;
    repeat (5) @(posedge i_sys_clk);
    ack_expect(1'b1, 8'h74);
    @(posedge i_sys_clk) i_isa_irq <= 16'h0;
    pulse_eoi(1'b1);
    i_pic_mask <= 16'h0020;
    i_isa_irq  <= 16'h0020;
    repeat (6) @(posedge i_sys_clk);
    #1 `CHK(o_intr, 1'b0)
    @(posedge i_sys_clk);
    i_isa_irq  <= 16'h0;
    i_pic_mask <= 16'hffff;
    for (int i = 0; i < 30; i++)
      check_route(~(30'h1 << i));
    for (int i = 0; i < 20; i++)
      check_route(30'($urandom));
    check_route('1);
    @(posedge i_sys_clk);
    i_apic_mode <= 1'b1;
    i_pic_mask  <= 16'h0;
    i_isa_irq   <= 16'h0010;
    ack_expect(1'b0, 8'h0);
    wait_msg(5'h04);
    @(posedge i_sys_clk);
    i_isa_irq <= 16'h0;
    i_map_wr  <= 1'b1;
    i_map_pin <= 5'h06;
    i_map_src <= 5'h1c;
    @(posedge i_sys_clk);
    i_map_pin <= 5'h1c;
    i_map_src <= 5'h00;
    @(posedge i_sys_clk);
    i_map_wr <= 1'b0;
    src_n    <= ~(30'h1 << 22);
    wait_msg(5'h06);
    `CHK(frame_err, 1'b0)
    finish_test();
  end
endmodule
